// ---- hdl/rcc_top.sv ----
// Calibration, output-pin selection and backup charger control
module rcc_top #(
  parameter int WINDOW_TICKS = rcc_pkg::CORR_WINDOW_DEF
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [rcc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [rcc_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [rcc_pkg::DATA_W-1:0] reg_rdata_out,
  // Nonvolatile store of the correction code
  input wire logic nv_restore_in,
  input wire logic [rcc_pkg::CODE_W-1:0] nv_code_in,
  output logic [rcc_pkg::CODE_W-1:0] nv_code_out,
  // Timebase
  input wire logic osc_clk_in,
  output logic corr_tick_out,
  // Alarm/wave pin
  input wire logic alarm_flag_enable_in,
  input wire logic alarm_active_in,
  output logic alarm_wave_out_pin_out,
  output logic alarm_wave_out_pin_oe_out,
  // Backup charger
  input wire logic backup_at_main_in,
  output logic backup_charge_on_out,
  output logic backup_fast_charge_out
);
  import rcc_pkg::*;

  logic cal_q;
  logic [CODE_W-1:0] code_q;
  logic charge_en_q;
  logic fast_q;
  logic alsw_q;
  rcc_freq_t freq_q;
  logic osc_prev_q;
  logic osc_lvl_q;
  logic [DIV_W-1:0] div_q;
  logic tick;
  logic wave_sel;
  logic corr_tick;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // Control register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cal_q <= 1'b0;
    end else if (reg_wr_in && hit(reg_addr_in, REG_CTRL)) begin
      cal_q <= reg_wdata_in[CTRL_CAL_BIT];
    end
  end

  // Correction code; mirrored out for the nonvolatile store
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_q <= CODE_RESET;
    end else if (nv_restore_in) begin
      code_q <= nv_code_in;
    end else if (reg_wr_in && hit(reg_addr_in, REG_CORR) && cal_q) begin
      code_q <= reg_wdata_in[CODE_W-1:0];
    end
  end
  assign nv_code_out = code_q;

  // Companion control register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      charge_en_q <= 1'b0;
      fast_q <= 1'b0;
      alsw_q <= 1'b0;
      freq_q <= RCC_F1;
    end else if (reg_wr_in && hit(reg_addr_in, REG_COMP)) begin
      charge_en_q <= reg_wdata_in[COMP_CHARGE_BIT];
      fast_q <= reg_wdata_in[COMP_FAST_BIT];
      alsw_q <= reg_wdata_in[COMP_ALSW_BIT];
      freq_q <= rcc_freq_t'(reg_wdata_in[COMP_FREQ_HI_BIT:COMP_FREQ_LO_BIT]);
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= '0;
      if (hit(reg_addr_in, REG_CTRL)) reg_rdata_out[CTRL_CAL_BIT] <= cal_q;
      if (hit(reg_addr_in, REG_CORR)) reg_rdata_out[CODE_W-1:0] <= code_q;
      if (hit(reg_addr_in, REG_COMP)) begin
        reg_rdata_out[COMP_CHARGE_BIT] <= charge_en_q;
        reg_rdata_out[COMP_FAST_BIT] <= fast_q;
        reg_rdata_out[COMP_ALSW_BIT] <= alsw_q;
        reg_rdata_out[COMP_FREQ_HI_BIT:COMP_FREQ_LO_BIT] <= freq_q;
      end
    end
  end

  // Uncorrected divider; all square waves but the 32768 Hz one tap here
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // High in reset, so an oscillator already high at release is no tick
      osc_prev_q <= 1'b1;
      osc_lvl_q <= 1'b0;
      div_q <= '0;
    end else begin
      osc_prev_q <= osc_clk_in;
      osc_lvl_q <= osc_clk_in;
      if (tick) div_q <= div_q + 1'b1;
    end
  end
  assign tick = osc_clk_in && !osc_prev_q;

  always_comb begin
    case (freq_q)
      RCC_F1: wave_sel = div_q[TAP_1];
      RCC_F512: wave_sel = div_q[TAP_512];
      RCC_F4096: wave_sel = div_q[TAP_4096];
      RCC_F32768: wave_sel = osc_lvl_q;
      default: wave_sel = 1'b0;
    endcase
  end

  // Alarm level is driven low while active, as an interrupt line would be
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_wave_out_pin_out <= 1'b0;
      alarm_wave_out_pin_oe_out <= 1'b0;
    end else if (cal_q) begin
      alarm_wave_out_pin_out <= div_q[TAP_512];
      alarm_wave_out_pin_oe_out <= 1'b1;
    end else if (!alsw_q) begin
      alarm_wave_out_pin_out <= wave_sel;
      alarm_wave_out_pin_oe_out <= 1'b1;
    end else begin
      alarm_wave_out_pin_out <= !alarm_active_in;
      alarm_wave_out_pin_oe_out <= alarm_flag_enable_in;
    end
  end

  // Charger stops once the backup pin reaches the main supply
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      backup_charge_on_out <= 1'b0;
      backup_fast_charge_out <= 1'b0;
    end else begin
      backup_charge_on_out <= charge_en_q && !backup_at_main_in;
      backup_fast_charge_out <= charge_en_q && !backup_at_main_in && fast_q;
    end
  end

  // Correction acts on the tick, never on the pin taps
  rcc_corrector #(.WINDOW_TICKS(WINDOW_TICKS)) u_corr (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .tick_in(tick),
    .code_in(code_q),
    .corr_tick_out(corr_tick)
  );
  assign corr_tick_out = corr_tick;

  chk_cal_enter: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    reg_wr_in && reg_addr_in == REG_CTRL |=> cal_q == $past(reg_wdata_in[CTRL_CAL_BIT]))
    else $error("calibration bit not taken");
  chk_code_ignored: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    reg_wr_in && reg_addr_in == REG_CORR && !cal_q && !nv_restore_in |=> $stable(code_q))
    else $error("code written outside calibration");
  chk_code_taken: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    reg_wr_in && reg_addr_in == REG_CORR && cal_q && !nv_restore_in
    |=> code_q == $past(reg_wdata_in[CODE_W-1:0])) else $error("code not taken");
  chk_cal_wave: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cal_q |=> alarm_wave_out_pin_oe_out && alarm_wave_out_pin_out == $past(div_q[TAP_512]))
    else $error("pin not showing 512 Hz");
  chk_pin_hiz: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !cal_q && alsw_q && !alarm_flag_enable_in |=> !alarm_wave_out_pin_oe_out)
    else $error("pin driven with alarm disabled");
  chk_charge_on: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    charge_en_q && !backup_at_main_in |=> backup_charge_on_out)
    else $error("charger not enabled");
  chk_fast_sel: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    backup_fast_charge_out |-> backup_charge_on_out && $past(fast_q))
    else $error("fast charge without enable");
endmodule // rcc_top

// ---- hdl/rcc_pkg.sv ----
// Constants for the clock-correction and backup-charge control block
package rcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CORR = 8'h01;
  localparam logic [7:0] REG_COMP = 8'h18;
  localparam int CTRL_CAL_BIT = 2;
  localparam int COMP_FAST_BIT = 2;
  localparam int COMP_CHARGE_BIT = 3;
  localparam int COMP_FREQ_LO_BIT = 4;
  localparam int COMP_FREQ_HI_BIT = 5;
  localparam int COMP_ALSW_BIT = 6;
  localparam int CODE_W = 6;
  localparam int MAG_W = 5;
  localparam int SIGN_BIT = 5;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam int OSC_HZ = 32768;
  localparam int CAL_HZ = 512;
  localparam int DIV_W = 15;
  // Divider bit toggling at a given rate: period in osc ticks is 2^(bit+1)
  localparam int TAP_512 = $clog2(OSC_HZ / CAL_HZ) - 1;
  localparam int TAP_1 = $clog2(OSC_HZ) - 1;
  localparam int TAP_4096 = $clog2(OSC_HZ / 4096) - 1;
  localparam int CORR_WINDOW_DEF = 230400;
  typedef enum logic [1:0] {RCC_F1, RCC_F512, RCC_F4096, RCC_F32768} rcc_freq_t;
endpackage

// ---- hdl/rcc_corrector.sv ----
// Pulse adder/remover acting on the undivided oscillator tick
module rcc_corrector #(
  parameter int WINDOW_TICKS = rcc_pkg::CORR_WINDOW_DEF
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Timebase
  input wire logic tick_in,
  input wire logic [rcc_pkg::CODE_W-1:0] code_in,
  output logic corr_tick_out
);
  import rcc_pkg::*;
  localparam int WIN_W = $clog2(WINDOW_TICKS);
  // Window must hold the largest magnitude, or corrections are cut short where done_q clears at the window end
  if (WINDOW_TICKS < 2 ** MAG_W) begin : g_window_check
    $error("WINDOW_TICKS below the largest correction magnitude");
  end
  logic [WIN_W-1:0] win_q;
  logic [MAG_W-1:0] done_q;
  logic extra_q;
  logic pending;
  logic sign;
  assign sign = code_in[SIGN_BIT];
  assign pending = done_q < code_in[MAG_W-1:0];

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      win_q <= '0;
      done_q <= '0;
    end else if (tick_in) begin
      if (win_q == WIN_W'(WINDOW_TICKS - 1)) begin
        win_q <= '0;
        done_q <= '0;
      end else begin
        win_q <= win_q + 1'b1;
        if (pending) done_q <= done_q + 1'b1;
      end
    end
  end

  // Ticks are at least two cycles apart, so the extra pulse never collides
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      corr_tick_out <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      corr_tick_out <= (tick_in && !(pending && !sign)) || extra_q;
      extra_q <= tick_in && pending && sign;
    end
  end

  chk_remove_tick: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tick_in && pending && !sign |=> !corr_tick_out) else $error("tick not removed");
  sequence s_double;
    corr_tick_out ##1 corr_tick_out;
  endsequence
  chk_add_tick: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tick_in && pending && sign |=> s_double) else $error("tick not added");
  chk_zero_code: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tick_in && code_in[MAG_W-1:0] == '0 |=> corr_tick_out ##1 !corr_tick_out)
    else $error("code zero altered timebase");
endmodule // rcc_corrector

// ---- test/rcc_host_model.sv ----
// Host side model driving the register strobes
module rcc_host_model import rcc_pkg::*; (
  // Clock and read data
  input wire logic clk_sys_in,
  input wire logic [rcc_pkg::DATA_W-1:0] reg_rdata_in,
  // Register strobes
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [rcc_pkg::ADDR_W-1:0] reg_addr_out,
  output logic [rcc_pkg::DATA_W-1:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // Released bus shows inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge clk_sys_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    reg_rd_out = 1'b1;
    reg_addr_out = a;
    @(posedge clk_sys_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(posedge clk_sys_in);
    #1;
    d = reg_rdata_in;
  endtask
endmodule // rcc_host_model

// ---- test/tb_top.sv ----
// Self-checking bench for calibration, pin select and charger control
module tb_top import rcc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic nv_restore_in = 1'b0;
  logic osc_clk_in = 1'b0;
  logic afe = 1'b0;
  logic aact = 1'b0;
  logic at_main = 1'b0;
  logic [5:0] nv_code_in = 6'h00;
  logic [5:0] nv_code;
  logic wr, rd, tick, pin, oe, chg, fast;
  logic [7:0] addr, wdata, rdata, v;
  logic [7:0] regs[4] = '{8'h00, 8'h01, 8'h18, 8'h02};
  logic [7:0] codes[5] = '{8'h00, 8'h21, 8'h3F, 8'h05, 8'h1F};
  int fp[4] = '{0, 256, 32, 4};
  int mismatches = 0;
  int checks_done = 0;
  int osc_cnt = 0;
  int n;
  always #5 clk_sys_in = ~clk_sys_in;
  // Oscillator tick every 4 system cycles keeps runs short
  always @(posedge clk_sys_in) begin
    #1;
    osc_cnt++;
    osc_clk_in = osc_cnt[1];
  end
  rcc_host_model h (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
  rcc_top #(.WINDOW_TICKS(64)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .nv_restore_in(nv_restore_in), .nv_code_in(nv_code_in),
    .nv_code_out(nv_code), .osc_clk_in(osc_clk_in), .corr_tick_out(tick),
    .alarm_flag_enable_in(afe), .alarm_active_in(aact), .alarm_wave_out_pin_out(pin),
    .alarm_wave_out_pin_oe_out(oe), .backup_at_main_in(at_main),
    .backup_charge_on_out(chg), .backup_fast_charge_out(fast));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask
  // Cycles between the first two rising pin edges, 0 if fewer seen
  task automatic per(output int p);
    int r;
    logic q;
    p = 0;
    r = -1;
    // One edge first, so a mode change is not taken for a rising edge
    @(posedge clk_sys_in);
    #1;
    q = pin;
    for (int i = 0; i < 700; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (pin && !q) begin
        if (r >= 0 && p == 0) p = i - r;
        r = i;
      end
      q = pin;
    end
  endtask
  // Span of four whole windows, so window phase cannot bias the count
  task automatic ticks(output int c);
    c = 0;
    repeat (1024) begin
      @(posedge clk_sys_in);
      #1;
      c += int'(tick);
    end
  endtask
  initial begin
    // About 2.3 times the expected run of some 12,800 cycles
    #300000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    foreach (regs[i]) begin
      h.rd(regs[i], v);
      chk(v, 8'h00);
    end
    h.wr(REG_CORR, 8'h21);
    h.rd(REG_CORR, v);
    chk(v, 8'h00);
    h.wr(REG_CTRL, 8'h04);
    h.rd(REG_CTRL, v);
    chk(v, 8'h04);
    // Alarm mode with alarm disabled: only calibration may drive the pin
    h.wr(REG_COMP, 8'h40);
    aact = 1'b1;
    foreach (codes[i]) begin
      h.wr(REG_CORR, codes[i]);
      h.rd(REG_CORR, v);
      chk(v, codes[i]);
      chk(nv_code, codes[i]);
      repeat (256) @(posedge clk_sys_in);
      ticks(n);
      chk(n, codes[i][5] ? 256 + 4 * codes[i][4:0] : 256 - 4 * codes[i][4:0]);
      per(n);
      chk(n, 256);
      chk(oe, 1'b1);
    end
    h.wr(REG_CTRL, 8'h00);
    h.wr(REG_CORR, 8'h05);
    chk(nv_code, 6'h1F);
    foreach (fp[i]) begin
      h.wr(REG_COMP, {2'b00, i[1:0], 4'h0});
      per(n);
      chk(n, fp[i]);
    end
    afe = 1'b1;
    h.wr(REG_COMP, 8'h40);
    settle;
    chk({oe, pin}, 2'b10);
    aact = 1'b0;
    settle;
    chk({oe, pin}, 2'b11);
    afe = 1'b0;
    settle;
    chk(oe, 1'b0);
    h.wr(REG_COMP, 8'h0C);
    h.rd(REG_COMP, v);
    chk({v, chg, fast}, {8'h0C, 2'b11});
    at_main = 1'b1;
    settle;
    chk({chg, fast}, 2'b00);
    at_main = 1'b0;
    h.wr(REG_COMP, 8'h08);
    settle;
    chk({chg, fast}, 2'b10);
    h.wr(REG_COMP, 8'h00);
    nv_code_in = 6'h2A;
    nv_restore_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    nv_restore_in = 1'b0;
    h.rd(REG_CORR, v);
    chk({v, chg}, {8'h2A, 1'b0});
    print_verdict;
  end
endmodule // tb_top
